// [include/rtcps_pkg.sv]
// Operation
// - With the fast square enable set and the main supply in use, the 32 kHz push-pull output follows the oscillator at 50% duty.
// - With the battery enable for the fast square also set, that output keeps toggling while running from the backup supply.
// - Whenever the fast square is not enabled for the present supply, its output is held low.
// - With the irq/square select at 0, the shared open-drain pin carries a continuous 1 Hz square wave.
// - With the select at 1, the shared pin is pulled low on a match of an enabled alarm, and never for a disabled one.
// - At power-up the control register at 0Eh comes up with the select at 1 and both alarms disabled.
// - The reset pin is pulled low whenever the main supply is below the power-fail threshold.
// - After the main supply recovers, reset stays asserted for the reset-active interval and is then released.
// - An outside low on the reset pin is a pushbutton request that is debounced before it acts.
// - With the oscillator disabled, the recovery delay is skipped and reset is released as soon as supply allows.
// - The reset pin is open-drain and is only ever driven low.
// - The oscillator halt flag is set by reset, and otherwise only after the oscillator has been stopped for the full stop delay.
// - The reset pin level does not disturb the serial interface or the timekeeping logic.
// - The serial interface accepts fast-mode transfers up to 400 kHz and standard-mode timing at any lower rate.
package rtcps_pkg;
  localparam int unsigned CORE_HZ = 20000000;
  localparam int unsigned TB_HZ = 32768;
  localparam int unsigned RECOVERY_MS = 250;
  localparam int unsigned DEBOUNCE_MS = 250;
  localparam int unsigned OSC_STOP_MS = 25;
  // least times round up to whole ticks
  localparam int unsigned RECOVERY_TICKS = (RECOVERY_MS * TB_HZ + 999) / 1000;
  localparam int unsigned DEBOUNCE_TICKS = (DEBOUNCE_MS * TB_HZ + 999) / 1000;
  localparam int unsigned OSC_STOP_CYCLES = (OSC_STOP_MS * (CORE_HZ / 1000));
  localparam int unsigned SLOW_DIV_BITS = 15;
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [7:0] CTRL_OFS = 8'h0E;
  localparam logic [7:0] STAT_OFS = 8'h0F;
  localparam int CTRL_A1_EN = 0;
  localparam int CTRL_A2_EN = 1;
  localparam int CTRL_SEL = 2;
  localparam int CTRL_FSQ_BATT = 6;
  localparam int STAT_A1_FLAG = 0;
  localparam int STAT_A2_FLAG = 1;
  localparam int STAT_FSQ_EN = 3;
  localparam int STAT_OSC_HALT = 7;
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] STAT_RST = 8'h88;
  localparam logic [7:0] CTRL_MASK = 8'h47;
  localparam logic [7:0] STAT_MASK = 8'h8B;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } rtcps_wr_s;
endpackage

// [src/rtcps_hold_timer.sv]
`timescale 1ns/1ps
// counts ticks while cond_in holds; any drop of cond_in restarts the count
module rtcps_hold_timer #(
  parameter int unsigned LIMIT = 8192,
  parameter int W = $clog2(LIMIT + 1)
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic cond_in,
  input wire logic tick_in,
  output logic done_out
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || !cond_in)
      cnt_r <= '0;
    else if (tick_in && cnt_r != W'(LIMIT))
      cnt_r <= cnt_r + 1'b1;
  end

  assign done_out = (cnt_r == W'(LIMIT));
endmodule

// [src/rtcps_top.sv]
`timescale 1ns/1ps
module rtcps_top #(
  parameter int unsigned RECOVERY_TICKS = rtcps_pkg::RECOVERY_TICKS,
  parameter int unsigned DEBOUNCE_TICKS = rtcps_pkg::DEBOUNCE_TICKS,
  parameter int unsigned OSC_STOP_CYCLES = rtcps_pkg::OSC_STOP_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // time base and supply status
  input wire logic osc_32k_in,
  input wire logic osc_enabled_in,
  input wire logic vcc_ok_in,
  input wire logic on_battery_in,
  // alarm match pulses from the calendar logic
  input wire logic alarm1_match_in,
  input wire logic alarm2_match_in,
  // output pins
  output logic fast_square_out,
  output logic irq_or_slow_square_out,
  output logic irq_or_slow_square_oe_n_out,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n_out
);
  typedef enum {RS_FAIL, RS_HOLD, RS_IDLE} rtcps_rst_e;
  typedef enum {I_IDLE, I_ADDR, I_ACK, I_WRITE, I_READ, I_MACK} rtcps_i2c_e;

  // pin synchronisers: stage 1 is read only by stage 2
  logic [6:0] sy1_r, sy2_r;
  logic scl_d_r, sda_d_r, osc_d_r;
  always_ff @(posedge core_clk_in)
  begin
    sy1_r <= {scl_in, sda_in, osc_32k_in, osc_enabled_in, vcc_ok_in, on_battery_in, reset_pin_in};
    sy2_r <= sy1_r;
    scl_d_r <= sy2_r[6];
    sda_d_r <= sy2_r[5];
    osc_d_r <= sy2_r[4];
  end
  logic scl_s, sda_s, osc_s, osc_en_s, vcc_ok_s, batt_s, rpin_s;
  assign {scl_s, sda_s, osc_s, osc_en_s, vcc_ok_s, batt_s, rpin_s} = sy2_r;
  logic tick_32k;
  assign tick_32k = osc_s && !osc_d_r;

  // registers
  logic [7:0] ctrl_r, stat_r;
  rtcps_pkg::rtcps_wr_s wr_r;
  logic osc_halt_set;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      ctrl_r <= rtcps_pkg::CTRL_RST;
    else if (wr_r.en && wr_r.addr == rtcps_pkg::CTRL_OFS)
      ctrl_r <= wr_r.data & rtcps_pkg::CTRL_MASK;
  end

  // flags clear on a written zero; a same-cycle event wins
  logic [7:0] stat_clr, stat_set;
  always_comb
  begin
    stat_clr = 8'h00;
    stat_set = 8'h00;
    if (wr_r.en && wr_r.addr == rtcps_pkg::STAT_OFS)
      stat_clr = ~wr_r.data;
    stat_set[rtcps_pkg::STAT_A1_FLAG] = alarm1_match_in;
    stat_set[rtcps_pkg::STAT_A2_FLAG] = alarm2_match_in;
    stat_set[rtcps_pkg::STAT_OSC_HALT] = osc_halt_set;
  end
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      stat_r <= rtcps_pkg::STAT_RST;
    else
    begin
      stat_r <= ((stat_r & ~stat_clr) | stat_set) & rtcps_pkg::STAT_MASK;
      if (wr_r.en && wr_r.addr == rtcps_pkg::STAT_OFS)
        stat_r[rtcps_pkg::STAT_FSQ_EN] <= wr_r.data[rtcps_pkg::STAT_FSQ_EN];
    end
  end

  // oscillator stop watchdog on core cycles between time base edges
  rtcps_hold_timer #(.LIMIT(OSC_STOP_CYCLES)) u_osc_stop (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .cond_in(!tick_32k),
    .tick_in(1'b1),
    .done_out(osc_halt_set)
  );

  // fast square and 1 Hz square
  logic fsq_allow;
  logic [rtcps_pkg::SLOW_DIV_BITS-1:0] slow_div_r;
  logic alarm_pend;
  assign fsq_allow = stat_r[rtcps_pkg::STAT_FSQ_EN] && (!batt_s || ctrl_r[rtcps_pkg::CTRL_FSQ_BATT]);
  assign alarm_pend = (stat_r[rtcps_pkg::STAT_A1_FLAG] && ctrl_r[rtcps_pkg::CTRL_A1_EN])
    || (stat_r[rtcps_pkg::STAT_A2_FLAG] && ctrl_r[rtcps_pkg::CTRL_A2_EN]);
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      slow_div_r <= '0;
      fast_square_out <= 1'b0;
      irq_or_slow_square_oe_n_out <= 1'b1;
      irq_or_slow_square_out <= 1'b0;
    end
    else
    begin
      if (tick_32k)
        slow_div_r <= slow_div_r + 1'b1;
      fast_square_out <= osc_s && fsq_allow;
      if (ctrl_r[rtcps_pkg::CTRL_SEL])
        irq_or_slow_square_oe_n_out <= !alarm_pend;
      else
        irq_or_slow_square_oe_n_out <= slow_div_r[rtcps_pkg::SLOW_DIV_BITS-1];
    end
  end

  // reset supervisor
  rtcps_rst_e rs_r;
  logic press_done, hold_done;
  rtcps_hold_timer #(.LIMIT(DEBOUNCE_TICKS)) u_debounce (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .cond_in(rs_r == RS_IDLE && !rpin_s),
    .tick_in(tick_32k),
    .done_out(press_done)
  );
  rtcps_hold_timer #(.LIMIT(RECOVERY_TICKS)) u_recover (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .cond_in(rs_r == RS_HOLD),
    .tick_in(tick_32k),
    .done_out(hold_done)
  );
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      rs_r <= RS_FAIL;
    else if (!vcc_ok_s)
      rs_r <= RS_FAIL;
    else
    begin
      unique case (rs_r)
        RS_FAIL: rs_r <= osc_en_s ? RS_HOLD : RS_IDLE;
        RS_HOLD: if (hold_done || !osc_en_s) rs_r <= RS_IDLE;
        RS_IDLE: if (press_done) rs_r <= RS_HOLD;
      endcase
    end
  end
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      reset_pin_oe_n_out <= 1'b0;
      reset_pin_out <= 1'b0;
      sda_out <= 1'b0;
    end
    else
      reset_pin_oe_n_out <= (rs_r == RS_IDLE);
  end

  // serial slave, oversampled at the core rate; never looks at the reset pin
  rtcps_i2c_e is_r;
  logic [7:0] shift_r, tx_r, ptr_r;
  logic [3:0] bits_r;
  logic first_r, rd_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] rd_data;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c = scl_s && scl_d_r && !sda_s && sda_d_r;
  assign stop_c = scl_s && scl_d_r && sda_s && !sda_d_r;
  always_comb
  begin
    if (ptr_r == rtcps_pkg::CTRL_OFS)
      rd_data = ctrl_r;
    else if (ptr_r == rtcps_pkg::STAT_OFS)
      rd_data = stat_r;
    else
      rd_data = 8'h00;
  end
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      is_r <= I_IDLE;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      bits_r <= 4'h0;
      first_r <= 1'b0;
      rd_r <= 1'b0;
      sda_oe_n_out <= 1'b1;
      wr_r <= '0;
    end
    else
    begin
      wr_r.en <= 1'b0;
      if (start_c)
      begin
        is_r <= I_ADDR;
        bits_r <= 4'h0;
        sda_oe_n_out <= 1'b1;
      end
      else if (stop_c)
      begin
        is_r <= I_IDLE;
        sda_oe_n_out <= 1'b1;
      end
      else if (scl_rise && is_r != I_IDLE)
      begin
        shift_r <= {shift_r[6:0], sda_s};
        bits_r <= bits_r + 4'h1;
      end
      else if (scl_fall)
      begin
        unique case (is_r)
          I_IDLE: ;
          I_ADDR:
            if (bits_r == 4'h8)
            begin
              if (shift_r[7:1] == rtcps_pkg::DEV_ADDR)
              begin
                rd_r <= shift_r[0];
                first_r <= !shift_r[0];
                sda_oe_n_out <= 1'b0;
                is_r <= I_ACK;
              end
              else
                is_r <= I_IDLE;
            end
          I_ACK:
          begin
            bits_r <= 4'h0;
            if (rd_r)
            begin
              tx_r <= {rd_data[6:0], 1'b0};
              sda_oe_n_out <= rd_data[7];
              ptr_r <= ptr_r + 8'h01;
              is_r <= I_READ;
            end
            else
            begin
              sda_oe_n_out <= 1'b1;
              is_r <= I_WRITE;
            end
          end
          I_WRITE:
            if (bits_r == 4'h8)
            begin
              if (first_r)
                ptr_r <= shift_r;
              else
              begin
                wr_r <= '{en: 1'b1, addr: ptr_r, data: shift_r};
                ptr_r <= ptr_r + 8'h01;
              end
              first_r <= 1'b0;
              sda_oe_n_out <= 1'b0;
              is_r <= I_ACK;
            end
          I_READ:
            if (bits_r == 4'h8)
            begin
              sda_oe_n_out <= 1'b1;
              is_r <= I_MACK;
            end
            else
            begin
              sda_oe_n_out <= tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          I_MACK:
            if (shift_r[0])
              is_r <= I_IDLE;
            else
            begin
              bits_r <= 4'h0;
              tx_r <= {rd_data[6:0], 1'b0};
              sda_oe_n_out <= rd_data[7];
              ptr_r <= ptr_r + 8'h01;
              is_r <= I_READ;
            end
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_fsq_gated: assert property (!fsq_allow |=> !fast_square_out) else $error("fast square not held low");
  chk_fsq_main: assert property (fsq_allow && osc_s |=> fast_square_out) else $error("fast square missing");
  chk_fsq_batt: assert property (batt_s && ctrl_r[rtcps_pkg::CTRL_FSQ_BATT] && stat_r[rtcps_pkg::STAT_FSQ_EN]
    |=> fast_square_out == $past(osc_s)) else $error("fast square wrong on battery");
  chk_sqw_mode: assert property (!ctrl_r[rtcps_pkg::CTRL_SEL]
    |=> irq_or_slow_square_oe_n_out == $past(slow_div_r[rtcps_pkg::SLOW_DIV_BITS-1]))
    else $error("slow square wrong");
  chk_alarm_gate: assert property (ctrl_r[2] && !alarm_pend |=> irq_or_slow_square_oe_n_out)
    else $error("pin asserted without enabled alarm");
  chk_alarm_hold: assert property (ctrl_r[2] && alarm_pend && !stat_clr[0] && !stat_clr[1] |=> alarm_pend ##1
    !irq_or_slow_square_oe_n_out) else $error("alarm pin dropped early");
  chk_fail_assert: assert property (!vcc_ok_s |=> ##1 !reset_pin_oe_n_out) else $error("reset not driven");
  chk_rst_low_only: assert property (!reset_pin_oe_n_out |-> reset_pin_out == 1'b0) else $error("reset driven high");
  chk_osc_bypass: assert property (rs_r == RS_FAIL && vcc_ok_s && !osc_en_s |=> rs_r == RS_IDLE)
    else $error("recovery not bypassed");
  chk_hold_time: assert property (rs_r == RS_HOLD && !hold_done && osc_en_s && vcc_ok_s |=> rs_r == RS_HOLD)
    else $error("reset released early");
  chk_osf_set: assert property (osc_halt_set |=> stat_r[7]) else $error("halt flag not set");
  chk_ctrl_reset: assert property ($rose(rst_n_in) |-> ctrl_r == rtcps_pkg::CTRL_RST) else $error("bad control reset");
  cov_power_up: cover property (rs_r == RS_HOLD ##1 rs_r == RS_IDLE);
  cov_push: cover property (rs_r == RS_IDLE && press_done);
  cov_alarm_irq: cover property (ctrl_r[2] && !irq_or_slow_square_oe_n_out);
  cov_reg_write: cover property (wr_r.en && wr_r.addr == rtcps_pkg::CTRL_OFS);
endmodule

// [verification/rtcps_i2c_model.sv]
`timescale 1ns/1ps
// bus master; one bit lasts 8 core cycles, a 400 ns serial clock at 20 MHz
module rtcps_i2c_model (
  // clock
  input wire logic core_clk_in,
  // bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  // scl high and low four cycles each, the least that the slave takes
  task automatic bit_io(input logic v, output logic r);
    sda_out <= v;
    wt(2);
    scl_out <= 1'b1;
    wt(2);
    r = sda_in;
    wt(2);
    scl_out <= 1'b0;
    wt(2);
  endtask
  task automatic start_c();
    sda_out <= 1'b1;
    scl_out <= 1'b1;
    wt(4);
    sda_out <= 1'b0;
    wt(4);
    scl_out <= 1'b0;
    wt(2);
  endtask
  task automatic stop_c();
    sda_out <= 1'b0;
    wt(2);
    scl_out <= 1'b1;
    wt(4);
    sda_out <= 1'b1;
    wt(4);
  endtask
  // ack_v high releases the line: slave ack on writes, master nack on reads
  task automatic byte_io(input logic [7:0] b, input logic ack_v, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r[i]);
    bit_io(ack_v, a);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] r;
    start_c();
    byte_io({rtcps_pkg::DEV_ADDR, 1'b0}, 1'b1, r);
    byte_io(ofs, 1'b1, r);
    byte_io(d, 1'b1, r);
    stop_c();
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] r;
    start_c();
    byte_io({rtcps_pkg::DEV_ADDR, 1'b0}, 1'b1, r);
    byte_io(ofs, 1'b1, r);
    stop_c();
    start_c();
    byte_io({rtcps_pkg::DEV_ADDR, 1'b1}, 1'b1, r);
    byte_io(8'hFF, 1'b1, d);
    stop_c();
  endtask
endmodule

// [verification/rtcps_top_test.sv]
`timescale 1ns/1ps
module rtcps_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc = 1'b0, osc_run = 1'b1, osc_en = 1'b1, vcc_ok = 1'b0, on_batt = 1'b0;
  logic a1 = 1'b0, a2 = 1'b0, pb_n = 1'b1;
  logic scl, m_sda, sda_o, sda_oe_n, fsq, irq_o, irq_oe_n, rst_o, rst_oe_n;
  wire sda_w = m_sda & (sda_oe_n | sda_o);
  wire rst_w = pb_n & (rst_oe_n | rst_o);
  int errors = 0;
  int n_checks = 0;
  int cnt = 0;
  logic [7:0] rd;
  always #25 clk = ~clk;
  // time base far faster than 32 kHz so that tick counts stay short
  always @(posedge clk)
  begin
    cnt <= (cnt == 19) ? 0 : cnt + 1;
    if (osc_run)
      osc <= (cnt < 10);
  end
  rtcps_top #(.RECOVERY_TICKS(8), .DEBOUNCE_TICKS(8), .OSC_STOP_CYCLES(100)) u_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .osc_32k_in(osc), .osc_enabled_in(osc_en),
    .vcc_ok_in(vcc_ok), .on_battery_in(on_batt), .alarm1_match_in(a1), .alarm2_match_in(a2),
    .fast_square_out(fsq), .irq_or_slow_square_out(irq_o), .irq_or_slow_square_oe_n_out(irq_oe_n),
    .reset_pin_in(rst_w), .reset_pin_out(rst_o), .reset_pin_oe_n_out(rst_oe_n));
  rtcps_i2c_model u_mst (.core_clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // called at a rising edge: the value seen is the one settled since the edge before
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic count_fsq(input logic [7:0] exp);
    int h;
    h = 0;
    wt(10);
    repeat (200)
    begin
      @(negedge clk);
      h += (fsq === 1'b1);
    end
    @(posedge clk);
    check("fast square highs", 8'(h), exp);
  endtask
  task automatic t_defaults();
    check("reset pin oe", rst_oe_n, 8'h00);
    check("irq pin oe", irq_oe_n, 8'h01);
    u_mst.rd(8'h0E, rd);
    check("control", rd, 8'h04);
    u_mst.rd(8'h0F, rd);
    check("status", rd, 8'h88);
    u_mst.rd(8'h10, rd);
    check("unmapped", rd, 8'h00);
    check("reset pin out", rst_o, 8'h00);
    check("irq pin out", irq_o, 8'h00);
    check("data pin out", sda_o, 8'h00);
    $display("test defaults done");
  endtask
  task automatic t_supervisor();
    wt(1);
    vcc_ok <= 1'b1;
    wt(120);
    check("reset held", rst_oe_n, 8'h00);
    wt(100);
    check("reset released", rst_w, 8'h01);
    wt(1);
    vcc_ok <= 1'b0;
    wt(5);
    check("reset on fail", rst_oe_n, 8'h00);
    wt(1);
    osc_en <= 1'b0;
    osc_run <= 1'b0;
    wt(10);
    vcc_ok <= 1'b1;
    wt(6);
    check("reset bypass", rst_oe_n, 8'h01);
    wt(1);
    osc_en <= 1'b1;
    osc_run <= 1'b1;
    $display("test supervisor done");
  endtask
  task automatic t_pushbutton();
    wt(300);
    pb_n <= 1'b0;
    wt(60);
    pb_n <= 1'b1;
    wt(2);
    check("short press", rst_oe_n, 8'h01);
    wt(1);
    pb_n <= 1'b0;
    wt(200);
    check("long press", rst_oe_n, 8'h00);
    wt(1);
    pb_n <= 1'b1;
    wt(300);
    check("press over", rst_oe_n, 8'h01);
    $display("test pushbutton done");
  endtask
  task automatic t_fast_square();
    u_mst.wr(8'h0F, 8'h08);
    count_fsq(8'd100);
    on_batt <= 1'b1;
    count_fsq(8'd0);
    u_mst.wr(8'h0E, 8'h44);
    count_fsq(8'd100);
    u_mst.wr(8'h0F, 8'h00);
    count_fsq(8'd0);
    on_batt <= 1'b0;
    $display("test fast square done");
  endtask
  task automatic t_alarm();
    u_mst.wr(8'h0E, 8'h05);
    a2 <= 1'b1;
    wt(1);
    a2 <= 1'b0;
    wt(5);
    check("disabled alarm", irq_oe_n, 8'h01);
    wt(1);
    a1 <= 1'b1;
    wt(1);
    a1 <= 1'b0;
    wt(50);
    check("alarm held", irq_oe_n, 8'h00);
    wt(1);
    u_mst.wr(8'h0F, 8'h00);
    check("alarm cleared", irq_oe_n, 8'h01);
    // the 1 Hz divider is far from its first half period here, so the pin is low
    u_mst.wr(8'h0E, 8'h00);
    wt(4);
    check("slow square low half", irq_oe_n, 8'h00);
    $display("test alarm done");
  endtask
  task automatic t_osc_halt();
    wt(1);
    u_mst.wr(8'h0F, 8'h00);
    osc_run <= 1'b0;
    wt(60);
    osc_run <= 1'b1;
    u_mst.rd(8'h0F, rd);
    check("short stop", rd, 8'h00);
    osc_run <= 1'b0;
    wt(200);
    osc_run <= 1'b1;
    u_mst.rd(8'h0F, rd);
    check("long stop", rd, 8'h80);
    $display("test osc halt done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #2ms;
    errors++;
    finish_test();
  end
  initial
  begin
    wt(16);
    rst_n <= 1'b1;
    wt(4);
    t_defaults();
    t_supervisor();
    t_pushbutton();
    t_fast_square();
    t_alarm();
    t_osc_halt();
    finish_test();
  end
endmodule
